// ==== logic/usart_frame_defs.svh ====
`ifndef USART_FRAME_DEFS_SVH
`define USART_FRAME_DEFS_SVH

`define ADDR_W            5
`define OFS_LINE_CTRL     5'h05
`define OFS_RXTX_CTRL     5'h06
`define OFS_FRAME_CTRL    5'h07
`define OFS_BLOCK_STATUS  5'h10

`define RST_LINE_CTRL     2'h0
`define RST_RXTX_CTRL     8'h00
`define RST_FRAME_CTRL    8'h03
`define RXTX_WR_MASK      8'hDF
`define SPI_VIEW_MASK     8'hC6
`define FULL_VIEW_MASK    8'hFF

`define B_RECEIVER_ENABLE_BIT            7
`define B_TRANSMITTER_ENABLE_BIT            6
`define B_START_FRAME_DETECT_ENABLE           4
`define B_OPEN_DRAIN_ENABLE            3
`define B_MULTIPROCESSOR_FILTER            0
`define F_RECEIVE_SPEED_MODE          2:1
`define F_COMMUNICATION_MODE           7:6
`define F_PARITY_MODE           5:4
`define B_STOP_BIT_MODE          3
`define F_CHARACTER_SIZE          2:0
`define B_ORDER           2
`define B_PHASE           1

`define LINE_OFF          2'h0
`define LINE_EXT          2'h1
`define LINE_INT          2'h2

`define RXM_NORMAL        2'h0
`define RXM_DOUBLE        2'h1
`define RXM_GENERIC_AUTOBAUD       2'h2
`define RXM_LIN_CONSTRAINED_AUTOBAUD       2'h3

`define COMMUNICATION_MODE_ASYNC       2'h0
`define COMMUNICATION_MODE_SYNC        2'h1
`define COMMUNICATION_MODE_IR          2'h2
`define COMMUNICATION_MODE_MASTER_SPI_OPTION        2'h3

`define PARITY_MODE_EVEN        2'h2
`define PARITY_MODE_ODD         2'h3

`define CHS_RSV4          3'h4
`define CHS_RSV5          3'h5
`define CHS_9L            3'h6
`define CHS_9H            3'h7

`define MIN_DATA_BITS     4'h5
`define DEF_DATA_BITS     4'h8
`define MAX_DATA_BITS     4'h9
`define DATA_MASK_ALL     9'h1FF

`define DIV_NORMAL        5'h10
`define DIV_DOUBLE        5'h08

`define SYNC_PAIRS        3'h4
`define LIN_PAIR_MIN      8'h1A
`define LIN_PAIR_MAX      8'h26
`define LIN_SYNC_CHAR     8'h55

`endif

// ==== logic/usart_frame_pkg.sv ====
package usart_frame_pkg;

  typedef enum logic [1:0] {AB_WAIT, AB_MEASURE, AB_CHECK} ab_state_t;

  typedef struct packed {
    logic [1:0] comm_mode;
    logic [1:0] rx_speed;
    logic       parity_en;
    logic       parity_odd;
    logic       two_stop;
    logic [3:0] data_bits;
    logic       nine_low_first;
    logic       lsb_first;
    logic       clock_phase;
    logic [4:0] baud_div;
    logic       mp_filter;
    logic       autobaud_on;
  } frame_cfg_t;

  typedef struct packed {
    logic       pair;
    logic [7:0] pair_len;
    logic       char_done;
    logic [7:0] char_data;
    logic       baud_ok;
  } sync_meas_t;

  typedef struct packed {
    logic [1:0] line;
    logic [7:0] rxtx;
    logic [7:0] frame;
    logic       tx_owned;
    logic       rx_prev;
    logic       parity_error_flag;
    logic       frame_error_flag;
    logic       ovf;
    logic       tx_par;
    logic [7:0] rdata;
    logic       flush;
    logic       abrst;
    logic       wake;
    logic       keep;
    ab_state_t  ab_st;
    logic [2:0] ab_cnt;
    logic       ab_bad;
    logic       ab_ok;
    logic       ab_fail;
    logic       txd;
    logic       txd_oe;
    logic       de;
  } ctrl_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_state_t;

endpackage : usart_frame_pkg

// ==== logic/pin_sync_filter.sv ====
`timescale 1ns/100ps
`include "usart_frame_defs.svh"

module pin_sync_filter
  import usart_frame_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic pin_i,
  output logic      level_o
);

  sync_state_t st_r;
  sync_state_t st_nxt;

  // s1 feeds only s2; the filter looks at s2 and s3
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pin_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.level = st_r.s3;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_r <= '{RESET_LEVEL, RESET_LEVEL, RESET_LEVEL, RESET_LEVEL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.level;

endmodule : pin_sync_filter

// ==== logic/usart_frame_ctrl.sv ====
// Overview of operation
// - line driver mode 0 off, 1 external driver pin, 2 internal transmitter, 3 reserved.
// - receiver enable owns receive pin; clearing flushes buffer and error flags; a frame or overflow in the clearing cycle still sets its flag.
// - clearing receiver enable in auto-baud modes resets auto-baud detection.
// - transmitter enable owns transmit pin; when disabled pin is released to input.
// - transmitter disable waits until shift register and buffer are empty.
// - start-frame detect wakes system on falling receive edge during sleep, except in master SPI mode.
// - open-drain mode drives transmit pin low only, never high.
// - receive mode 0 normal, 1 double, 2 generic auto-baud, 3 LIN auto-baud.
// - double speed in asynchronous mode divides baud by 8 instead of 16.
// - generic auto-baud accepts sync after eight bits if baud is valid.
// - LIN auto-baud needs every bit pair within 32 plus minus 6, value 0x55.
// - auto-baud modes work only as asynchronous slave.
// - multiprocessor filter drops frames without address; transmitter unaffected.
// - communication mode 0 async, 1 sync, 2 infrared, 3 master SPI.
// - in master SPI the frame register shows communication mode, bit order and clock phase only.
// - parity enabled: transmitter appends parity, receiver flags mismatches.
// - parity mode 0 off, 1 reserved, 2 even, 3 odd.
// - stop bit mode 0 one, 1 two; receiver ignores it.
// - character size 5 to 8 bits, 4 and 5 reserved, 6 and 7 nine bits.
// - SPI bit order 0 MSB first, 1 LSB first, both directions.
// - SPI clock phase picks leading or trailing sampling edge.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`include "usart_frame_defs.svh"

module usart_frame_ctrl
  import usart_frame_pkg::*;
(
  input  wire logic               core_clk_i,
  input  wire logic               sys_rst_i,
  input  wire logic [`ADDR_W-1:0] reg_addr_i,
  input  wire logic [7:0]         reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic [7:0]              reg_rdata_o,
  input  wire logic               rx_pin_i,
  input  wire logic               sleep_i,
  input  wire logic               tx_serial_i,
  input  wire logic               tx_active_i,
  input  wire logic               tx_shift_busy_i,
  input  wire logic               tx_buf_full_i,
  input  wire logic [8:0]         tx_data_i,
  input  wire logic [8:0]         rx_data_i,
  input  wire logic               rx_parity_bit_i,
  input  wire logic               rx_frame_valid_i,
  input  wire logic               rx_addr_bit_i,
  input  wire logic               frame_err_i,
  input  wire logic               overflow_i,
  input  wire sync_meas_t         meas_i,
  output frame_cfg_t              cfg_o,
  output logic                    rx_level_o,
  output logic                    rx_pin_owned_o,
  output logic                    rx_flush_o,
  output logic                    autobaud_reset_o,
  output logic                    sync_accept_o,
  output logic                    sync_reject_o,
  output logic                    frame_keep_o,
  output logic                    parity_error_o,
  output logic                    frame_error_o,
  output logic                    overflow_o,
  output logic                    tx_parity_o,
  output logic                    txd_o,
  output logic                    txd_oe_o,
  output logic                    tx_pin_owned_o,
  output logic                    driver_enable_pin_o,
  output logic                    wake_o
);

  ctrl_state_t st_r;
  ctrl_state_t st_nxt;
  frame_cfg_t  cfg;
  logic        rx_level;
  logic        is_master_spi_option;
  logic        rx_on;
  logic [8:0]  bit_mask;
  logic        rx_calc_par;
  logic        lin_mode;
  logic        pair_bad;

  pin_sync_filter #(
    .RESET_LEVEL (1'b1)
  ) u_rx_sync (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .pin_i      (rx_pin_i),
    .level_o    (rx_level)
  );

  assign is_master_spi_option = (st_r.frame[`F_COMMUNICATION_MODE] == `COMMUNICATION_MODE_MASTER_SPI_OPTION);
  assign rx_on   = st_r.rxtx[`B_RECEIVER_ENABLE_BIT];

  // field decode; reserved encodings fall back to a harmless setting
  always_comb begin
    cfg                = '0;
    cfg.comm_mode      = st_r.frame[`F_COMMUNICATION_MODE];
    cfg.rx_speed       = st_r.rxtx[`F_RECEIVE_SPEED_MODE];
    cfg.mp_filter      = st_r.rxtx[`B_MULTIPROCESSOR_FILTER];
    cfg.baud_div       = `DIV_NORMAL;
    // double speed only counts in async; other modes keep 16
    if (cfg.rx_speed == `RXM_DOUBLE && cfg.comm_mode == `COMMUNICATION_MODE_ASYNC) begin
      cfg.baud_div = `DIV_DOUBLE;
    end
    // auto-baud only as asynchronous slave
    cfg.autobaud_on = cfg.rx_speed[1] && (cfg.comm_mode == `COMMUNICATION_MODE_ASYNC);
    if (is_master_spi_option) begin
      cfg.data_bits   = `DEF_DATA_BITS;
      cfg.lsb_first   = st_r.frame[`B_ORDER];
      cfg.clock_phase = st_r.frame[`B_PHASE];
    end else begin
      // 0x1 reserved leaves parity off
      cfg.parity_en  = (st_r.frame[`F_PARITY_MODE] == `PARITY_MODE_EVEN) ||
                       (st_r.frame[`F_PARITY_MODE] == `PARITY_MODE_ODD);
      cfg.parity_odd = (st_r.frame[`F_PARITY_MODE] == `PARITY_MODE_ODD);
      cfg.two_stop   = st_r.frame[`B_STOP_BIT_MODE];
      case (st_r.frame[`F_CHARACTER_SIZE])
        `CHS_9L: begin
          cfg.data_bits      = `MAX_DATA_BITS;
          cfg.nine_low_first = 1'b1;
        end
        `CHS_9H: begin
          cfg.data_bits = `MAX_DATA_BITS;
        end
        `CHS_RSV4, `CHS_RSV5: begin
          cfg.data_bits = `DEF_DATA_BITS;
        end
        default: begin
          cfg.data_bits = `MIN_DATA_BITS +
                          {2'h0, st_r.frame[1:0]};
        end
      endcase
    end
  end

  assign bit_mask    = `DATA_MASK_ALL >> (`MAX_DATA_BITS - cfg.data_bits);
  assign rx_calc_par = (^(rx_data_i & bit_mask)) ^ cfg.parity_odd;
  assign lin_mode    = (cfg.rx_speed == `RXM_LIN_CONSTRAINED_AUTOBAUD);
  assign pair_bad    = (meas_i.pair_len < `LIN_PAIR_MIN) ||
                       (meas_i.pair_len > `LIN_PAIR_MAX);

  always_comb begin
    st_nxt         = st_r;
    st_nxt.flush   = 1'b0;
    st_nxt.abrst   = 1'b0;
    st_nxt.wake    = 1'b0;
    st_nxt.keep    = 1'b0;
    st_nxt.ab_ok   = 1'b0;
    st_nxt.ab_fail = 1'b0;
    st_nxt.rdata   = 8'h00;
    st_nxt.rx_prev = rx_level;

    if (reg_rd_i) begin
      case (reg_addr_i)
        `OFS_LINE_CTRL:    st_nxt.rdata = {6'h00, st_r.line};
        `OFS_RXTX_CTRL:    st_nxt.rdata = st_r.rxtx;
        // SPI view hides the async-only fields
        `OFS_FRAME_CTRL:   st_nxt.rdata = is_master_spi_option ?
                             (st_r.frame & `SPI_VIEW_MASK) : st_r.frame;
        `OFS_BLOCK_STATUS: st_nxt.rdata = {st_r.tx_owned, rx_on,
                             rx_level, (st_r.ab_st != AB_WAIT),
                             1'b0, st_r.parity_error_flag, st_r.frame_error_flag, st_r.ovf};
        default:           st_nxt.rdata = 8'h00;
      endcase
    end

    if (reg_wr_i) begin
      case (reg_addr_i)
        `OFS_LINE_CTRL:  st_nxt.line = reg_wdata_i[1:0];
        `OFS_RXTX_CTRL:  st_nxt.rxtx = reg_wdata_i & `RXTX_WR_MASK;
        `OFS_FRAME_CTRL: st_nxt.frame = reg_wdata_i &
          ((reg_wdata_i[`F_COMMUNICATION_MODE] == `COMMUNICATION_MODE_MASTER_SPI_OPTION) ?
           `SPI_VIEW_MASK : `FULL_VIEW_MASK);
        default: ;
      endcase
    end

    // turning the receiver off flushes and resets detection
    if (rx_on && !st_nxt.rxtx[`B_RECEIVER_ENABLE_BIT]) begin
      st_nxt.flush  = 1'b1;
      st_nxt.parity_error_flag   = 1'b0;
      st_nxt.frame_error_flag   = 1'b0;
      st_nxt.ovf    = 1'b0;
      st_nxt.ab_st  = AB_WAIT;
      st_nxt.ab_cnt = 3'h0;
      st_nxt.ab_bad = 1'b0;
      st_nxt.abrst  = cfg.rx_speed[1];
    end

    // frames without address are dropped in multiprocessor mode
    if (rx_frame_valid_i && rx_on &&
        (!cfg.mp_filter || rx_addr_bit_i)) begin
      st_nxt.keep = 1'b1;
      // a frame in the flush cycle still sets its flags
      if (cfg.parity_en) begin
        st_nxt.parity_error_flag = (rx_calc_par != rx_parity_bit_i);
      end
      if (frame_err_i) begin
        st_nxt.frame_error_flag = 1'b1;
      end
    end
    if (overflow_i && rx_on) begin
      st_nxt.ovf = 1'b1;
    end

    // release waits for an idle transmit path
    if (st_r.rxtx[`B_TRANSMITTER_ENABLE_BIT]) begin
      st_nxt.tx_owned = 1'b1;
    end else if (!tx_shift_busy_i && !tx_buf_full_i) begin
      st_nxt.tx_owned = 1'b0;
    end

    st_nxt.tx_par = (^(tx_data_i & bit_mask)) ^ cfg.parity_odd;

    // transmit pin: released pin is undriven open drain
    st_nxt.txd    = st_r.rxtx[`B_OPEN_DRAIN_ENABLE] ? 1'b0 : tx_serial_i;
    st_nxt.txd_oe = st_r.tx_owned &&
                    (!st_r.rxtx[`B_OPEN_DRAIN_ENABLE] || !tx_serial_i) &&
                    (st_r.line != `LINE_INT || tx_active_i);
    st_nxt.de     = (st_r.line == `LINE_EXT) && st_r.tx_owned &&
                    tx_active_i;

    // wake on idle-to-start edge while asleep
    st_nxt.wake = st_r.rxtx[`B_START_FRAME_DETECT_ENABLE] && !is_master_spi_option && sleep_i &&
                  st_r.rx_prev && !rx_level;

    // a pair in the disable cycle must not restart detection
    if (rx_on && st_nxt.rxtx[`B_RECEIVER_ENABLE_BIT] && cfg.autobaud_on) begin
      case (st_r.ab_st)
        AB_WAIT: begin
          if (meas_i.pair) begin
            st_nxt.ab_st  = AB_MEASURE;
            st_nxt.ab_cnt = 3'h1;
            st_nxt.ab_bad = lin_mode && pair_bad;
          end
        end
        AB_MEASURE: begin
          if (meas_i.pair) begin
            st_nxt.ab_cnt = st_r.ab_cnt + 3'h1;
            st_nxt.ab_bad = st_r.ab_bad || (lin_mode && pair_bad);
            // eight low and high bits make four pairs
            if (st_r.ab_cnt + 3'h1 == `SYNC_PAIRS) begin
              if (lin_mode) begin
                st_nxt.ab_st = AB_CHECK;
              end else begin
                st_nxt.ab_st   = AB_WAIT;
                st_nxt.ab_ok   = meas_i.baud_ok;
                st_nxt.ab_fail = !meas_i.baud_ok;
              end
            end
          end
        end
        AB_CHECK: begin
          if (meas_i.char_done) begin
            st_nxt.ab_st = AB_WAIT;
            if (!st_r.ab_bad && meas_i.baud_ok &&
                meas_i.char_data == `LIN_SYNC_CHAR) begin
              st_nxt.ab_ok = 1'b1;
            end else begin
              st_nxt.ab_fail = 1'b1;
            end
          end
        end
        default: begin
          st_nxt.ab_st = AB_WAIT;
        end
      endcase
    end else if (!cfg.autobaud_on) begin
      st_nxt.ab_st  = AB_WAIT;
      st_nxt.ab_cnt = 3'h0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_r          <= '0;
      st_r.line     <= `RST_LINE_CTRL;
      st_r.rxtx     <= `RST_RXTX_CTRL;
      st_r.frame    <= `RST_FRAME_CTRL;
      st_r.rx_prev  <= 1'b1;
      st_r.ab_st    <= AB_WAIT;
      st_r.txd      <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg_o               = cfg;
  assign reg_rdata_o         = st_r.rdata;
  assign rx_level_o          = rx_level;
  assign rx_pin_owned_o      = rx_on;
  assign rx_flush_o          = st_r.flush;
  assign autobaud_reset_o    = st_r.abrst;
  assign sync_accept_o       = st_r.ab_ok;
  assign sync_reject_o       = st_r.ab_fail;
  assign frame_keep_o        = st_r.keep;
  assign parity_error_o      = st_r.parity_error_flag;
  assign frame_error_o       = st_r.frame_error_flag;
  assign overflow_o          = st_r.ovf;
  assign tx_parity_o         = st_r.tx_par;
  assign txd_o               = st_r.txd;
  assign txd_oe_o            = st_r.txd_oe;
  assign tx_pin_owned_o      = st_r.tx_owned;
  assign driver_enable_pin_o = st_r.de;
  assign wake_o              = st_r.wake;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_rx_off_flush: assert property (
    $fell(st_r.rxtx[`B_RECEIVER_ENABLE_BIT])
      |-> st_r.flush && (!st_r.ovf || $past(overflow_i)))
    else $error("receiver disable did not flush");

  a_rx_off_abreset: assert property (
    $fell(st_r.rxtx[`B_RECEIVER_ENABLE_BIT]) && $past(cfg.rx_speed[1])
      |-> st_r.abrst && st_r.ab_st == AB_WAIT)
    else $error("auto-baud logic not reset");

  a_tx_hold_busy: assert property (
    st_r.tx_owned && !st_r.rxtx[`B_TRANSMITTER_ENABLE_BIT] && tx_shift_busy_i
      |=> st_r.tx_owned)
    else $error("transmit pin released while busy");

  a_tx_pin_release: assert property (
    !st_r.tx_owned |=> !txd_oe_o)
    else $error("released transmit pin still driven");

  a_open_drain_low: assert property (
    $past(st_r.rxtx[`B_OPEN_DRAIN_ENABLE]) && txd_oe_o |-> !txd_o)
    else $error("open drain pin driven high");

  a_ext_driver_pin: assert property (
    driver_enable_pin_o |-> $past(st_r.line) == `LINE_EXT &&
      $past(tx_active_i))
    else $error("driver enable outside external mode");

  a_double_divider: assert property (
    cfg.rx_speed == `RXM_DOUBLE && cfg.comm_mode == `COMMUNICATION_MODE_ASYNC
      |-> cfg.baud_div == `DIV_DOUBLE)
    else $error("double speed divider wrong");

  a_lin_sync_char: assert property (
    sync_accept_o && $past(lin_mode)
      |-> $past(meas_i.char_data) == `LIN_SYNC_CHAR)
    else $error("LIN sync accepted with wrong value");

  a_mp_discard: assert property (
    $past(rx_frame_valid_i) && $past(cfg.mp_filter) &&
      !$past(rx_addr_bit_i) |-> !frame_keep_o)
    else $error("data frame kept in multiprocessor mode");

  a_spi_view_read: assert property (
    reg_rd_i && reg_addr_i == `OFS_FRAME_CTRL && is_master_spi_option
      |=> (reg_rdata_o & ~`SPI_VIEW_MASK) == 8'h00)
    else $error("SPI view shows async fields");

  a_wake_edge: assert property (
    wake_o |-> $past(st_r.rxtx[`B_START_FRAME_DETECT_ENABLE]) && !$past(rx_level))
    else $error("wake without start edge");

  c_sync_accept: cover property (sync_accept_o);
  c_tx_release:  cover property ($fell(st_r.tx_owned));
  c_wake:        cover property (wake_o);
  c_rx_flush:    cover property (rx_flush_o);

endmodule : usart_frame_ctrl

// ==== testbench/serial_node_model.sv ====
`timescale 1ns/100ps

module serial_node_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic load_i,
  input  wire logic txd_i,
  input  wire logic txd_oe_i,
  output logic      serial_o,
  output logic      active_o,
  output logic      busy_o,
  output logic      full_o,
  output logic      line_o
);
  logic [3:0] cnt_r;

  // the buffer drains early, so a disable meets both drain phases
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 4'h0;
    end else if (load_i) begin
      cnt_r <= 4'hC;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  assign busy_o   = cnt_r != 4'h0;
  assign active_o = busy_o;
  assign full_o   = cnt_r > 4'h8;
  // alternating bits, so a stale value never looks right
  assign serial_o = busy_o ? cnt_r[0] : 1'b1;
  // pull-up holds the wire high when nobody drives it
  assign line_o   = txd_oe_i ? txd_i : 1'b1;
endmodule : serial_node_model

// ==== testbench/usart_frame_ctrl_tb.sv ====
`timescale 1ns/100ps

module usart_frame_ctrl_tb
  import usart_frame_pkg::*;
;
  logic       clk, rst, wr, rd, rx_pin, sleep, load, fv, rpar, radr;
  logic       frame_error_flag, ovf, tser, tact, tbusy, tfull, line, tpar;
  logic       flush, abr, acc, rej, keep, parity_error_flag, fer, ovo, wake;
  logic       txd, oe, towned, de, rlev, rown;
  logic [4:0] addr, seen;
  logic [7:0] wdata, rdata;
  logic [8:0] rxd;
  sync_meas_t meas;
  frame_cfg_t cfg;
  int         errors, cmp_count, cyc_n;
  logic [7:0] lens [5] = '{8'h1A, 8'h26, 8'h27, 8'h19, 8'h20};
  logic [7:0] chars [5] = '{8'h55, 8'h55, 8'h55, 8'h55, 8'h54};

  usart_frame_ctrl usart_frame_ctrl_i (
    .core_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .rx_pin_i(rx_pin), .sleep_i(sleep),
    .tx_serial_i(tser), .tx_active_i(tact), .tx_shift_busy_i(tbusy),
    .tx_buf_full_i(tfull), .tx_data_i(rxd), .rx_data_i(rxd),
    .rx_parity_bit_i(rpar), .rx_frame_valid_i(fv),
    .rx_addr_bit_i(radr), .frame_err_i(frame_error_flag), .overflow_i(ovf),
    .meas_i(meas), .cfg_o(cfg), .rx_level_o(rlev),
    .rx_pin_owned_o(rown), .rx_flush_o(flush), .autobaud_reset_o(abr),
    .sync_accept_o(acc), .sync_reject_o(rej), .frame_keep_o(keep),
    .parity_error_o(parity_error_flag), .frame_error_o(fer), .overflow_o(ovo),
    .tx_parity_o(tpar), .txd_o(txd), .txd_oe_o(oe),
    .tx_pin_owned_o(towned), .driver_enable_pin_o(de), .wake_o(wake));

  serial_node_model serial_node_model_i (
    .clk_i(clk), .rst_i(rst), .load_i(load), .txd_i(txd),
    .txd_oe_i(oe), .serial_o(tser), .active_o(tact), .busy_o(tbusy),
    .full_o(tfull), .line_o(line));

  task chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task rd_chk(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd_chk

  // ors the flush, auto-baud reset, accept, reject and wake pulses over n cycles
  task win(input int n);
    // pulses launched at the edge before the call count too
    seen = {flush, abr, acc, rej, wake};
    repeat (n) begin
      @(posedge clk);
      #1 seen |= {flush, abr, acc, rej, wake};
    end
  endtask : win

  task frame(input logic [8:0] d, input logic p, a, fe);
    @(posedge clk);
    rxd  <= d;
    rpar <= p;
    radr <= a;
    frame_error_flag <= fe;
    fv   <= 1'b1;
    @(posedge clk);
    fv <= 1'b0;
    #1;
  endtask : frame

  task send(input logic [7:0] len, input logic ok);
    meas.baud_ok <= ok;
    repeat (4) begin
      @(posedge clk);
      meas.pair     <= 1'b1;
      meas.pair_len <= len;
      @(posedge clk);
      meas.pair <= 1'b0;
    end
  endtask : send

  task sync_char(input logic [7:0] c);
    @(posedge clk);
    meas.char_done <= 1'b1;
    meas.char_data <= c;
    @(posedge clk);
    meas.char_done <= 1'b0;
  endtask : sync_char

  task load_frame;
    @(posedge clk);
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
  endtask : load_frame

  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      errors++;
      end_sim;
    end
  end

  initial begin
    {rst, wr, rd, sleep, load, fv, rpar, radr, frame_error_flag, ovf} = 10'h200;
    rx_pin = 1'b1;
    addr   = 5'h00;
    wdata  = 8'h00;
    rxd    = 9'h000;
    meas   = '0;
    cyc(3);
    rst <= 1'b0;
    rd_chk(5'h06, 8'h00);
    rd_chk(5'h07, 8'h03);
    rd_chk(5'h05, 8'h00);
    wr_reg(5'h06, 8'hFF);
    rd_chk(5'h06, 8'hDF);
    rd_chk(5'h1F, 8'h00);
    wr_reg(5'h06, 8'h00);
    $display("done registers");
    for (int m = 0; m < 4; m++) begin
      wr_reg(5'h07, {m[1:0], 6'h03});
      chk(cfg.comm_mode, m[1:0]);
    end
    wr_reg(5'h07, 8'hFF);
    rd_chk(5'h07, 8'hC6);
    chk(cfg.lsb_first, 1'b1);
    chk(cfg.clock_phase, 1'b1);
    chk(cfg.parity_en, 1'b0);
    wr_reg(5'h07, 8'hC0);
    chk(cfg.lsb_first, 1'b0);
    chk(cfg.clock_phase, 1'b0);
    for (int p = 0; p < 4; p++) begin
      for (int s = 0; s < 8; s++) begin
        wr_reg(5'h07, {2'b00, p[1:0], p[0], s[2:0]});
        chk(cfg.parity_en, p[1]);
        chk(cfg.two_stop, p[0]);
        if (p[1]) chk(cfg.parity_odd, p[0]);
        chk(cfg.data_bits, s < 4 ? 4'h5 + s[3:0] : s[1] ? 4'h9 : 4'h8);
        chk(cfg.nine_low_first, s == 6);
      end
    end
    wr_reg(5'h07, 8'h03);
    for (int m = 0; m < 4; m++) begin
      wr_reg(5'h06, {5'h00, m[1:0], 1'b0});
      chk(cfg.rx_speed, m[1:0]);
      chk(cfg.baud_div, m == 1 ? 5'h08 : 5'h10);
      chk(cfg.autobaud_on, m[1]);
    end
    $display("done decode");
    wr_reg(5'h06, 8'h40);
    cyc(2);
    chk(towned, 1'b1);
    load_frame;
    cyc(2);
    chk(oe, 1'b1);
    wr_reg(5'h06, 8'h00);
    cyc(2);
    chk(towned, 1'b1);
    cyc(16);
    chk(towned, 1'b0);
    chk(oe, 1'b0);
    wr_reg(5'h06, 8'h48);
    load_frame;
    repeat (10) begin
      @(posedge clk);
      #1 chk(oe & txd, 1'b0);
    end
    wr_reg(5'h05, 8'h01);
    load_frame;
    cyc(3);
    chk(de, 1'b1);
    cyc(14);
    wr_reg(5'h05, 8'h02);
    cyc(2);
    chk(oe, 1'b0);
    wr_reg(5'h05, 8'h00);
    wr_reg(5'h06, 8'h00);
    cyc(16);
    $display("done transmit");
    wr_reg(5'h07, 8'h23);
    wr_reg(5'h06, 8'h80);
    cyc(2);
    chk(rown, 1'b1);
    frame(9'h007, 1'b0, 1'b0, 1'b0);
    chk(keep, 1'b1);
    chk(parity_error_flag, 1'b1);
    cyc(1);
    chk(tpar, 1'b1);
    frame(9'h007, 1'b1, 1'b0, 1'b1);
    chk(parity_error_flag, 1'b0);
    chk(fer, 1'b1);
    @(posedge clk);
    ovf <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
    #1 chk(ovo, 1'b1);
    wr_reg(5'h07, 8'h33);
    frame(9'h007, 1'b0, 1'b0, 1'b0);
    chk(parity_error_flag, 1'b0);
    wr_reg(5'h06, 8'h81);
    frame(9'h007, 1'b1, 1'b0, 1'b0);
    chk(keep, 1'b0);
    chk(parity_error_flag, 1'b0);
    frame(9'h007, 1'b1, 1'b1, 1'b0);
    chk(keep, 1'b1);
    wr_reg(5'h06, 8'h00);
    win(4);
    chk(seen[4], 1'b1);
    chk({parity_error_flag, fer, ovo, rown}, 4'h0);
    $display("done receive");
    wr_reg(5'h06, 8'h84);
    wr_reg(5'h06, 8'h04);
    win(4);
    chk(seen[3], 1'b1);
    for (int k = 0; k < 2; k++) begin
      wr_reg(5'h06, 8'h84);
      fork
        send(8'h20, k == 0);
        win(12);
      join
      chk(seen[2:1], k == 0 ? 2'b10 : 2'b01);
      wr_reg(5'h06, 8'h00);
    end
    for (int k = 0; k < 5; k++) begin
      wr_reg(5'h06, 8'h86);
      fork
        begin
          send(lens[k], 1'b1);
          sync_char(chars[k]);
        end
        win(16);
      join
      chk(seen[2:1], k < 2 ? 2'b10 : 2'b01);
      wr_reg(5'h06, 8'h00);
    end
    $display("done autobaud");
    wr_reg(5'h06, 8'h10);
    @(posedge clk);
    sleep  <= 1'b1;
    rx_pin <= 1'b0;
    win(8);
    chk(seen[0], 1'b1);
    chk(rlev, 1'b0);
    @(posedge clk);
    sleep  <= 1'b0;
    rx_pin <= 1'b1;
    cyc(6);
    rx_pin <= 1'b0;
    win(8);
    chk(seen[0], 1'b0);
    $display("done wake");
    end_sim;
  end
endmodule : usart_frame_ctrl_tb
